// ===== inc/tsbf_pkg.sv
// Constants and types of the six-slot TDMA burst framer.
// Assumes a 50 MHz system clock and a symbol-rate clock enable.
package tsbf_pkg;
  localparam logic [2:0] SLOTS     = 3'h6;
  localparam logic [2:0] LAST_SLOT = 3'h5;
  localparam logic [2:0] PAIR_OFS  = 3'h3;
  localparam logic [8:0] LAST_BIT  = 9'h143;
  // Uplink traffic burst field starts
  localparam logic [8:0] UT_R  = 9'h006;
  localparam logic [8:0] UT_D1 = 9'h00C;
  localparam logic [8:0] UT_S  = 9'h01C;
  localparam logic [8:0] UT_D2 = 9'h038;
  localparam logic [8:0] UT_SA = 9'h0B2;
  localparam logic [8:0] UT_CD = 9'h0BE;
  localparam logic [8:0] UT_D3 = 9'h0CA;
  // Downlink traffic burst field starts
  localparam logic [8:0] DT_SA = 9'h01C;
  localparam logic [8:0] DT_D1 = 9'h028;
  localparam logic [8:0] DT_CD = 9'h0AA;
  localparam logic [8:0] DT_D2 = 9'h0B6;
  localparam logic [8:0] DT_SP = 9'h138;
  // Shortened burst field starts
  localparam logic [8:0] SH_S  = 9'h00C;
  localparam logic [8:0] SH_CD = 9'h028;
  localparam logic [8:0] SH_I  = 9'h034;
  localparam logic [8:0] POS0  = 9'h000;
  // Field widths as top bit index
  localparam logic [4:0] SYNC_MSB = 5'h1B;
  localparam logic [3:0] CW_MSB   = 4'hB;
  localparam logic [2:0] GR_MSB   = 3'h5;
  localparam logic [5:0] GUARD_VAL = 6'h00;
  localparam logic [5:0] RAMP_VAL  = 6'h00;
  localparam logic [11:0] CDVCC_DEF = 12'h013;
  localparam logic [11:0] SPARE_DEF = 12'h000;
  localparam logic [7:0] REDUCED_LEVEL_DEF = 8'h28;
  localparam logic [7:0] REDUCED_LEVEL_MAX = 8'hFF;
  localparam logic [7:0] REDUCED_LEVEL_NONE = 8'h00;
  localparam logic [27:0] SYNC_DEF [6] = '{28'hA91DE4A, 28'hA9D127A, 28'hC7E3C0C,
                                          28'h342C3F3, 28'h13E23D1, 28'hDC2EC1D};
  // Register map (byte addresses)
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_REDUCED_LEVEL = 8'h04;
  localparam logic [7:0] OFS_STAT  = 8'h08;
  localparam logic [7:0] OFS_GR    = 8'h0C;
  localparam logic [7:0] OFS_LIST  = 8'h10;
  localparam logic [7:0] OFS_DFLT  = 8'h14;
  localparam logic [3:0] SLOT_NIB0 = 4'h4;
  localparam logic [3:0] SLOT_NIBN = 4'h9;
  localparam logic [1:0] SUB_CFG   = 2'h0;
  localparam logic [1:0] SUB_SYNC  = 2'h1;
  localparam logic [1:0] SUB_CODE  = 2'h2;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_DN  = 1;
  localparam int CTRL_RATE_LO = 2;
  localparam int CTRL_PN_LO   = 5;
  localparam int STAT_ERR = 3;
  localparam int SPARE_LO = 16;
  localparam int GR_RAMP_LO = 8;
  // PRBS output and feedback tap positions
  localparam int PN9_N = 8;
  localparam int PN9_K = 4;
  localparam int PN15_N = 14;
  localparam int PN15_K = 13;
  localparam int PN23_N = 22;
  localparam int PN23_K = 17;
  localparam logic [22:0] PRBS_SEED = 23'h7FFFFF;

  typedef enum logic [1:0] {BT_TCH = 2'b00, BT_ALL = 2'b01, BT_SHORT = 2'b10} tsbf_burst_t;
  typedef enum logic [1:0] {LV_OFF = 2'b00, LV_FULL = 2'b01, LV_RED = 2'b10} tsbf_level_t;
  typedef enum logic [1:0] {SRC_PRBS = 2'b00, SRC_LIST = 2'b01, SRC_SER = 2'b10} tsbf_src_t;
  typedef enum logic [1:0] {PN9 = 2'b00, PN15 = 2'b01, PN23 = 2'b10} tsbf_pn_t;
  typedef enum logic [2:0] {F_GUARD = 3'b000, F_RAMP = 3'b001, F_SYNC = 3'b010,
                            F_DATA = 3'b011, F_SACCH = 3'b100, F_CDVCC = 3'b101,
                            F_SPARE = 3'b110, F_IDLE = 3'b111} tsbf_field_t;
  typedef struct packed {
    tsbf_burst_t btype;
    logic        active;
    tsbf_level_t level;
    tsbf_src_t   dsrc;
    tsbf_src_t   ssrc;
  } tsbf_cfg_t;
  typedef struct packed {
    tsbf_field_t code;
    logic [8:0]  start;
  } tsbf_fld_t;
  typedef struct packed {
    logic        valid;
    logic        bit_o;
    tsbf_level_t level;
    logic [7:0]  reduced_level;
    logic [2:0]  slot;
  } tsbf_tx_t;
  localparam tsbf_cfg_t CFG_DEF = '{BT_TCH, 1'b1, LV_FULL, SRC_PRBS, SRC_PRBS};
endpackage

// ===== verilog/tsbf_framer.sv
// Six-slot TDMA burst framer with an Avalon-MM register slave.
// Assumes ce marks symbol-rate steps and ser_data is valid when ser_take is high.
// Notes on behaviour
// - Three pairings; full-rate joins slot n, n+3.
// - Second paired slot uses first slot's settings.
// - Six slots; paired second slots not configurable.
// - Each slot has its own active flag.
// - Uplink power off, full or reduced level.
// - Downlink burst on sends configured fields.
// - Downlink burst off sends all ones.
// - Downlink sends every slot at full level.
// - Uplink guard and ramp, six bits, read-only.
// - Payload fields form one continuous PRBS stream.
// - Payload source PRBS, stored list or serial.
// - Control channel field has own source.
// - 28-bit sync word, per-slot defaults.
// - Colour code sent as entered, default 013.
// - Downlink 12-bit spare field sent unchanged.
// - All-data burst carries only payload, after guard and ramp on uplink.
// - Shortened burst rejected on downlink.
// - Per-slot default command restores settings.
// - Reduced level uses common attenuation in dB.
// - Direction picks burst layouts and fields.
`timescale 1ns/10ps
module tsbf_framer
  import tsbf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ser_data,
  output logic             ser_take,
  output tsbf_tx_t         tx
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Master slot of a pair, else the slot itself
  function automatic logic [2:0] eff_slot(input logic [2:0] s, input logic [2:0] rate);
    logic [2:0] d;
    logic [3:0] r4;
    d  = s - PAIR_OFS;
    r4 = {1'b0, rate};
    eff_slot = (s >= PAIR_OFS && r4[d[1:0]]) ? d : s;
  endfunction

  // Field at a bit position for burst type and direction
  function automatic tsbf_fld_t fld_at(input logic [8:0] p, input tsbf_burst_t bt,
                                       input logic dn);
    fld_at = '{F_DATA, POS0};
    if (!dn && bt != BT_TCH && p < UT_R) begin
      fld_at = '{F_GUARD, POS0};
    end else if (!dn && bt != BT_TCH && p < UT_D1) begin
      fld_at = '{F_RAMP, UT_R};
    end else if (bt == BT_ALL) begin
      fld_at = '{F_DATA, POS0};
    end else if (dn) begin
      if (p < DT_SA) fld_at = '{F_SYNC, POS0};
      else if (p < DT_D1) fld_at = '{F_SACCH, DT_SA};
      else if (p < DT_CD) fld_at = '{F_DATA, DT_D1};
      else if (p < DT_D2) fld_at = '{F_CDVCC, DT_CD};
      else if (p < DT_SP) fld_at = '{F_DATA, DT_D2};
      else fld_at = '{F_SPARE, DT_SP};
    end else if (bt == BT_SHORT) begin
      if (p < SH_CD) fld_at = '{F_SYNC, SH_S};
      else if (p < SH_I) fld_at = '{F_CDVCC, SH_CD};
      else fld_at = '{F_IDLE, SH_I};
    end else begin
      if (p < UT_R) fld_at = '{F_GUARD, POS0};
      else if (p < UT_D1) fld_at = '{F_RAMP, UT_R};
      else if (p < UT_S) fld_at = '{F_DATA, UT_D1};
      else if (p < UT_D2) fld_at = '{F_SYNC, UT_S};
      else if (p < UT_SA) fld_at = '{F_DATA, UT_D2};
      else if (p < UT_CD) fld_at = '{F_SACCH, UT_SA};
      else if (p < UT_D3) fld_at = '{F_CDVCC, UT_CD};
      else fld_at = '{F_DATA, UT_D3};
    end
  endfunction

  logic        ack_reg;
  logic        run_reg;
  logic        dn_reg;
  logic [2:0]  rate_reg;
  tsbf_pn_t    pn_reg;
  logic [7:0]  reduced_level_reg;
  logic        err_reg;
  logic [31:0] list_reg;
  tsbf_cfg_t   cfg_reg   [6];
  logic [27:0] sync_reg  [6];
  logic [11:0] cdvcc_reg [6];
  logic [11:0] spare_reg [6];
  logic [8:0]  bit_cnt;
  logic [2:0]  slot_cnt;
  logic [22:0] lfsr_reg  [2];
  logic [4:0]  lptr_reg  [2];

  // Bus handshake: waitrequest held until the second ce step of each access
  wire         req     = avs_read | avs_write;
  wire         done    = req & ack_reg & ce;
  wire         wr      = done & avs_write;
  assign avs_waitrequest = req & ~(ack_reg & ce);

  wire [3:0]   nib     = avs_address[7:4];
  wire [1:0]   sub     = avs_address[3:2];
  wire         is_slot = (nib >= SLOT_NIB0) && (nib <= SLOT_NIBN);
  wire [2:0]   a_slot  = 3'(nib - SLOT_NIB0);
  // Paired second slots take no writes
  // dependent slots locked
  wire         indep   = eff_slot(a_slot, rate_reg) == a_slot;
  wire         wr_slot = wr & is_slot & indep;
  wire         wr_cfg  = wr_slot && sub == SUB_CFG;
  tsbf_cfg_t   w_cfg;
  assign w_cfg = tsbf_cfg_t'(avs_writedata[8:0]);
  wire         short_rej = wr_cfg && dn_reg && w_cfg.btype == BT_SHORT;
  wire         wr_ctrl = wr && avs_address == OFS_CTRL;
  wire         wr_att  = wr && avs_address == OFS_REDUCED_LEVEL;
  wire         wr_stat = wr && avs_address == OFS_STAT;
  wire         wr_list = wr && avs_address == OFS_LIST;
  wire [2:0]   d_slot  = avs_writedata[2:0];
  wire         dflt    = wr && avs_address == OFS_DFLT && d_slot < SLOTS;

  wire [31:0] rd_slot = (sub == SUB_CFG)  ? {23'h0, cfg_reg[a_slot]} :
                        (sub == SUB_SYNC) ? {4'h0, sync_reg[a_slot]} :
                        (sub == SUB_CODE) ? {4'h0, spare_reg[a_slot], 4'h0,
                                             cdvcc_reg[a_slot]} : 32'h0;
  wire [31:0] rd_val  = (avs_address == OFS_CTRL)  ? {25'h0, pn_reg, rate_reg, dn_reg,
                                                      run_reg} :
                        (avs_address == OFS_REDUCED_LEVEL) ? {24'h0, reduced_level_reg} :
                        (avs_address == OFS_STAT)  ? {28'h0, err_reg, slot_cnt} :
                        (avs_address == OFS_GR)    ? {18'h0, RAMP_VAL, 2'h0, GUARD_VAL} :
                        (avs_address == OFS_LIST)  ? list_reg :
                        is_slot                    ? rd_slot : 32'h0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h0;
    end else if (ce) begin
      ack_reg <= req & ~ack_reg;
      if (req & ~ack_reg) avs_readdata <= rd_val;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_reg   <= 1'b0;
      dn_reg    <= 1'b0;
      rate_reg  <= 3'h0;
      pn_reg    <= PN9;
      reduced_level_reg <= REDUCED_LEVEL_DEF;
      list_reg  <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        run_reg  <= avs_writedata[CTRL_RUN];
        dn_reg   <= avs_writedata[CTRL_DN];
        rate_reg <= avs_writedata[CTRL_RATE_LO +: 3];
        pn_reg   <= tsbf_pn_t'(avs_writedata[CTRL_PN_LO +: 2]);
      end
      if (wr_att) reduced_level_reg <= avs_writedata[7:0];
      if (wr_list) list_reg <= avs_writedata;
    end
  end

  // Sticky refusal flag, set beats clear
  always_ff @(posedge clk) begin
    if (sys_rst) err_reg <= 1'b0;
    else if (short_rej) err_reg <= 1'b1;
    else if (wr_stat && avs_writedata[STAT_ERR]) err_reg <= 1'b0;
  end

  // Slot settings store
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 6; i++) begin
        cfg_reg[i]   <= CFG_DEF;
        sync_reg[i]  <= SYNC_DEF[i];
        cdvcc_reg[i] <= CDVCC_DEF;
        spare_reg[i] <= SPARE_DEF;
      end
    end else if (dflt) begin
      cfg_reg[d_slot]   <= CFG_DEF;
      sync_reg[d_slot]  <= SYNC_DEF[d_slot];
      cdvcc_reg[d_slot] <= CDVCC_DEF;
      spare_reg[d_slot] <= SPARE_DEF;
    end else if (wr_slot) begin
      if (sub == SUB_CFG && !short_rej) cfg_reg[a_slot] <= w_cfg;
      if (sub == SUB_SYNC) sync_reg[a_slot] <= avs_writedata[27:0];
      if (sub == SUB_CODE) begin
        cdvcc_reg[a_slot] <= avs_writedata[11:0];
        spare_reg[a_slot] <= avs_writedata[SPARE_LO +: 12];
      end
    end
  end

  // Slot and bit position
  wire step = ce & run_reg;
  // slots one to six in turn
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt  <= 9'h000;
      slot_cnt <= 3'h0;
    end else if (ce && !run_reg) begin
      bit_cnt  <= 9'h000;
      slot_cnt <= 3'h0;
    end else if (step) begin
      if (bit_cnt == LAST_BIT) begin
        bit_cnt  <= 9'h000;
        slot_cnt <= (slot_cnt == LAST_SLOT) ? 3'h0 : 3'(slot_cnt + 3'h1);
      end else begin
        bit_cnt <= 9'(bit_cnt + 9'h001);
      end
    end
  end

  wire [2:0]  cur_idx = eff_slot(slot_cnt, rate_reg);
  tsbf_cfg_t  cur;
  assign cur = cfg_reg[cur_idx];
  tsbf_fld_t  fl;
  assign fl = fld_at(bit_cnt, cur.btype, dn_reg);
  wire [8:0]  off    = 9'(bit_cnt - fl.start);
  wire        blank  = dn_reg & ~cur.active;
  wire        emit   = step & ~blank;

  // Payload and control channel sources
  tsbf_src_t  src_sel [2];
  logic       ch_use  [2];
  logic       ch_bit  [2];
  logic       pn_out  [2];
  logic       ser_use [2];
  for (genvar c = 0; c < 2; c++) begin : g_src
    wire [22:0] l    = lfsr_reg[c];
    assign pn_out[c] = (pn_reg == PN23) ? l[PN23_N] :
                       (pn_reg == PN15) ? l[PN15_N] : l[PN9_N];
    wire        fb   = (pn_reg == PN23) ? l[PN23_N] ^ l[PN23_K] :
                       (pn_reg == PN15) ? l[PN15_N] ^ l[PN15_K] : l[PN9_N] ^ l[PN9_K];
    assign src_sel[c] = (c == 0) ? cur.dsrc : cur.ssrc;
    assign ch_use[c]  = emit && fl.code == ((c == 0) ? F_DATA : F_SACCH);
    assign ser_use[c] = ch_use[c] && src_sel[c] == SRC_SER;
    assign ch_bit[c]  = (src_sel[c] == SRC_LIST) ? list_reg[lptr_reg[c]] :
                        (src_sel[c] == SRC_SER)  ? ser_data : pn_out[c];
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        lfsr_reg[c] <= PRBS_SEED;
        lptr_reg[c] <= 5'h00;
      end else if (ch_use[c]) begin
        if (src_sel[c] == SRC_PRBS) lfsr_reg[c] <= {l[21:0], fb};
        if (src_sel[c] == SRC_LIST) lptr_reg[c] <= 5'(lptr_reg[c] + 5'h01);
      end
    end
  end
  assign ser_take = ser_use[0] | ser_use[1];

  wire gr_bit = (fl.code == F_GUARD) ? GUARD_VAL[3'(GR_MSB - off[2:0])] :
                                       RAMP_VAL[3'(GR_MSB - off[2:0])];
  wire fbit   = (fl.code == F_GUARD || fl.code == F_RAMP) ? gr_bit :
                (fl.code == F_SYNC)  ? sync_reg[cur_idx][5'(SYNC_MSB - off[4:0])] :
                (fl.code == F_DATA)  ? ch_bit[0] :
                (fl.code == F_SACCH) ? ch_bit[1] :
                (fl.code == F_CDVCC) ? cdvcc_reg[cur_idx][4'(CW_MSB - off[3:0])] :
                (fl.code == F_SPARE) ? spare_reg[cur_idx][4'(CW_MSB - off[3:0])] : 1'b0;
  wire cur_bit = blank | fbit;

  tsbf_level_t cur_lvl;
  assign cur_lvl = dn_reg ? LV_FULL : (cur.active ? cur.level : LV_OFF);
  wire [7:0] cur_att = (cur_lvl == LV_RED) ? reduced_level_reg :
                       (cur_lvl == LV_OFF) ? REDUCED_LEVEL_MAX : REDUCED_LEVEL_NONE;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx <= '{1'b0, 1'b0, LV_OFF, REDUCED_LEVEL_NONE, 3'h0};
    end else if (ce) begin
      tx <= '{run_reg, cur_bit, cur_lvl, cur_att, slot_cnt};
    end
  end

  sequence s_frame_end;
    step && bit_cnt == LAST_BIT && slot_cnt == LAST_SLOT;
  endsequence
  sequence s_frame_start;
    bit_cnt == 9'h000 && slot_cnt == 3'h0;
  endsequence

  property p_pair;
    slot_cnt >= PAIR_OFS && rate_reg[2'(slot_cnt - PAIR_OFS)] |-> cur_idx == slot_cnt - PAIR_OFS;
  endproperty
  a_pair: assert property (p_pair) else $error("paired slot not taken from master");

  property p_ones;
    ce && run_reg && dn_reg && !cur.active |=> tx.valid && tx.bit_o;
  endproperty
  a_ones: assert property (p_ones) else $error("burst off slot not all ones");

  property p_dnlvl;
    ce && dn_reg |=> tx.level == LV_FULL && tx.reduced_level == REDUCED_LEVEL_NONE;
  endproperty
  a_dnlvl: assert property (p_dnlvl) else $error("downlink level not full");

  property p_red;
    ce && !dn_reg && cur.active && cur.level == LV_RED |=> tx.reduced_level == $past(reduced_level_reg);
  endproperty
  a_red: assert property (p_red) else $error("reduced slot not attenuated");

  property p_short;
    short_rej |=> err_reg && cfg_reg[$past(a_slot)] == $past(cfg_reg[a_slot]);
  endproperty
  a_short: assert property (p_short) else $error("short burst accepted on downlink");

  property p_wrap;
    s_frame_end |=> s_frame_start;
  endproperty
  a_wrap: assert property (p_wrap) else $error("frame did not wrap to slot one");

  property p_dflt;
    dflt |=> cdvcc_reg[$past(d_slot)] == CDVCC_DEF && cfg_reg[$past(d_slot)] == CFG_DEF;
  endproperty
  a_dflt: assert property (p_dflt) else $error("slot default not restored");

  property p_prbs;
    !(ch_use[0] && src_sel[0] == SRC_PRBS) |=> $stable(lfsr_reg[0]);
  endproperty
  a_prbs: assert property (p_prbs) else $error("payload sequence moved while idle");
endmodule

// ===== tb/tsbf_ser_model.sv
// Serial payload source standing at the framer's serial input.
// Assumes ser_take marks a consumed bit at a clock edge with ce high.
`timescale 1ns/10ps
module tsbf_ser_model
  import tsbf_pkg::*;
#(
  parameter logic [31:0] PAT = 32'hC35A96E1
)(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic ser_take,
  output logic      ser_data
);
  logic [4:0] idx_reg;
  // Bits in pattern order, inverted while not taken
  assign ser_data = ser_take ? PAT[idx_reg] : ~PAT[idx_reg];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idx_reg <= 5'h00;
    end else if (ce && ser_take) begin
      idx_reg <= idx_reg + 5'h01;
    end
  end
endmodule

// ===== tb/tsbf_framer_tb.sv
// Self-checking bench of the burst framer: register access and bit stream.
// Assumes the serial source model and a free-running 50 MHz clock.
`timescale 1ns/10ps
module tsbf_framer_tb
  import tsbf_pkg::*;
;
  localparam logic [31:0] SPAT = 32'hC35A96E1;
  logic        clk;
  logic        sys_rst;
  logic        ce;
  logic        avs_read;
  logic        avs_write;
  logic        avs_waitrequest;
  logic        ser_data;
  logic        ser_take;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  tsbf_tx_t    tx;
  int          n_errors;
  int          n_compared;
  int          ones;
  logic        cap_b [648];
  tsbf_level_t cap_l [648];
  logic [7:0]  cap_a [648];
  logic [2:0]  cap_s [648];

  tsbf_framer DUT (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .ce              (ce),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .ser_data        (ser_data),
    .ser_take        (ser_take),
    .tx              (tx)
  );
  tsbf_ser_model #(.PAT(SPAT)) u_ser (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .ser_take (ser_take),
    .ser_data (ser_data)
  );

  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic finish_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 100) begin
      @(posedge clk);
      k++;
    end
    if (k == 100) begin
      n_errors++;
      finish_test();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e, "register");
  endtask

  function automatic logic [7:0] sa(input int n, input int o);
    return 8'h40 + 8'(n * 16 + o);
  endfunction

  // Stream field from captured bits, first bit most significant
  function automatic logic [31:0] fld(input int s, input int w);
    logic [31:0] v;
    v = '0;
    for (int i = 0; i < w; i++) begin
      v = {v[30:0], cap_b[s + i]};
    end
    return v;
  endfunction

  // Expected field from a word sent lowest bit first
  function automatic logic [31:0] lsbf(input logic [31:0] p, input int w);
    logic [31:0] v;
    v = '0;
    for (int i = 0; i < w; i++) begin
      v = {v[30:0], p[i]};
    end
    return v;
  endfunction

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
  endtask

  task automatic check_defaults();
    for (int n = 0; n < 6; n++) begin
      rdm(sa(n, 4), 32'hFFFFFFFF, 32'(SYNC_DEF[n]));
      rdm(sa(n, 8), 32'h00000FFF, 32'h013);
      rdm(sa(n, 0), 32'hFFFFFFFF, 32'h050);
    end
  endtask

  // Two slots of stream, skip bits after the first valid bit
  task automatic grab(input int skip);
    int k;
    k = 0;
    while (tx.valid !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    if (k == 100) begin
      n_errors++;
      finish_test();
    end
    repeat (skip) @(posedge clk);
    for (int i = 0; i < 648; i++) begin
      cap_b[i] = tx.bit_o;
      cap_l[i] = tx.level;
      cap_a[i] = tx.reduced_level;
      cap_s[i] = tx.slot;
      @(posedge clk);
    end
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    finish_test();
  end

  initial begin
    n_errors = 0;
    n_compared = 0;
    sys_rst = 1'b1;
    ce = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    do_reset();
    rdm(OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    rdm(OFS_REDUCED_LEVEL, 32'hFFFFFFFF, 32'h28);
    wr(OFS_GR, 32'hFFFF);
    rdm(OFS_GR, 32'hFFFFFFFF, 32'h0);
    rdm(8'h20, 32'hFFFFFFFF, 32'h0);
    check_defaults();
    wr(OFS_CTRL, 32'h2);
    wr(sa(0, 0), 32'h150);
    rdm(sa(0, 0), 32'hFFFFFFFF, 32'h050);
    rdm(OFS_STAT, 32'h8, 32'h8);
    wr(OFS_STAT, 32'h8);
    rdm(OFS_STAT, 32'h8, 32'h0);
    wr(OFS_CTRL, 32'h0);
    wr(sa(0, 0), 32'h150);
    rdm(sa(0, 0), 32'hFFFFFFFF, 32'h150);
    for (int j = 0; j < 3; j++) begin
      wr(OFS_CTRL, 32'h4 << j);
      wr(sa(j + 3, 4), 32'h1111111);
      wr(sa(j, 4), 32'h2222222);
      wr(OFS_CTRL, 32'h0);
      rdm(sa(j + 3, 4), 32'hFFFFFFFF, 32'(SYNC_DEF[j + 3]));
      rdm(sa(j, 4), 32'hFFFFFFFF, 32'h2222222);
    end
    wr(sa(3, 4), 32'h1111111);
    rdm(sa(3, 4), 32'hFFFFFFFF, 32'h1111111);
    wr(sa(5, 8), 32'hABC);
    for (int n = 0; n < 6; n++) begin
      wr(OFS_DFLT, 32'(n));
    end
    check_defaults();
    do_reset();
    wr(sa(0, 0), 32'h059);
    wr(sa(0, 8), 32'hABC);
    wr(OFS_LIST, 32'h0000F0F5);
    wr(OFS_REDUCED_LEVEL, 32'h10);
    wr(sa(1, 0), 32'h060);
    wr(OFS_CTRL, 32'h1);
    grab(0);
    chk(fld(0, 6), 32'h0, "guard");
    chk(fld(6, 6), 32'h0, "ramp");
    chk(fld(12, 16), lsbf(SPAT, 16), "serial data");
    chk(fld(28, 28), 32'hA91DE4A, "sync slot 1");
    chk(fld(178, 12), lsbf(32'hF0F5, 12), "sacch");
    chk(fld(190, 12), 32'hABC, "colour code");
    chk(32'(cap_s[323]), 32'h0, "slot index");
    chk(32'(cap_s[324]), 32'h1, "slot index");
    chk(fld(352, 28), 32'hA9D127A, "sync slot 2");
    chk(32'(cap_l[0]), 32'(LV_FULL), "level");
    chk(32'(cap_a[0]), 32'h0, "reduced_level");
    chk(32'(cap_l[400]), 32'(LV_RED), "level");
    chk(32'(cap_a[400]), 32'h10, "reduced_level");
    do_reset();
    wr(sa(0, 0), 32'h010);
    wr(sa(1, 0), 32'h060);
    wr(OFS_REDUCED_LEVEL, 32'h10);
    wr(sa(1, 8), 32'h05A50013);
    wr(OFS_CTRL, 32'h3);
    grab(0);
    ones = 0;
    for (int i = 0; i < 324; i++) begin
      ones += int'(cap_b[i] === 1'b1);
    end
    chk(32'(ones), 32'd324, "burst off ones");
    chk(fld(324, 28), 32'hA9D127A, "downlink sync");
    chk(fld(494, 12), 32'h013, "downlink colour code");
    chk(fld(636, 12), 32'h5A5, "spare field");
    chk(32'(cap_l[400]), 32'(LV_FULL), "downlink level");
    chk(32'(cap_a[400]), 32'h0, "downlink reduced_level");
    // Slot six paired with inactive slot three, then wrap to slot one
    wr(sa(2, 0), 32'h010);
    wr(OFS_CTRL, 32'h12);
    wr(OFS_CTRL, 32'h13);
    grab(1620);
    ones = 0;
    for (int i = 0; i < 324; i++) begin
      ones += int'(cap_b[i] === 1'b1);
    end
    chk(32'(ones), 32'd324, "paired slot follows master");
    chk(32'(cap_s[323]), 32'h5, "last slot index");
    chk(32'(cap_s[324]), 32'h0, "frame wrap");
    // Clock enable low holds the stream
    ce <= 1'b0;
    @(posedge clk);
    rd = 32'(tx);
    repeat (20) @(posedge clk);
    chk(32'(tx), rd, "frozen stream");
    ce <= 1'b1;
    wr(OFS_CTRL, 32'h12);
    rdm(OFS_STAT, 32'h7, 32'h0);
    finish_test();
  end
endmodule
